// ---- pkg/cse_pkg.sv ----
// Purpose: shared constants and types for the converter/system executor
// Assumes: 10-bit instruction words, 4-bit accumulators
// Notes: opcode values are the machine codes of the instruction set
package cse_pkg;

  // Widths
  localparam int INSTR_W = 10;
  localparam int NIB_W = 4;
  localparam int ADC_W = 10;
  localparam int CMP_W = 8;

  // Opcodes
  localparam logic [INSTR_W-1:0] OP_MOVE_RESULT_TO_ACC_PAIR = 10'h279;
  localparam logic [INSTR_W-1:0] OP_MOVE_RESULT_LOW_BITS = 10'h249;
  localparam logic [INSTR_W-1:0] OP_WRITE_COMPARATOR_REFERENCE = 10'h239;
  localparam logic [INSTR_W-1:0] OP_COPY_CONVERTER_CONTROL_TO_ACC = 10'h244;
  localparam logic [INSTR_W-1:0] OP_COPY_ACC_TO_CONVERTER_CONTROL = 10'h204;
  localparam logic [INSTR_W-1:0] OP_START_CONVERSION = 10'h29F;
  localparam logic [INSTR_W-1:0] OP_SKIP_ON_CONVERSION_DONE = 10'h287;
  localparam logic [INSTR_W-1:0] OP_NO_OPERATION = 10'h000;
  localparam logic [INSTR_W-1:0] OP_ENTER_RAM_BACKUP = 10'h002;
  localparam logic [INSTR_W-1:0] OP_ARM_RAM_BACKUP = 10'h05B;
  localparam logic [INSTR_W-1:0] OP_SKIP_ON_BACKUP_RETURN_FLAG = 10'h003;
  localparam logic [INSTR_W-1:0] OP_ARM_WATCHDOG_STOP = 10'h29C;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_RESTART_SKIP = 10'h2A0;
  localparam logic [INSTR_W-1:0] OP_SOFTWARE_SYSTEM_RESET = 10'h001;
  localparam logic [INSTR_W-1:0] OP_CLEAR_UPPER_REF_ENABLE = 10'h058;
  localparam logic [INSTR_W-1:0] OP_SET_UPPER_REF_ENABLE = 10'h059;
  localparam logic [INSTR_W-1:0] OP_ENABLE_VOLTAGE_DROP_DETECT = 10'h293;

  // Field positions
  localparam int CONVERTER_MODE_BIT = 3;

  // Reset values
  localparam logic [NIB_W-1:0] CONV_CTRL_RST = 4'h0;
  localparam logic [CMP_W-1:0] CMP_REF_RST = 8'h00;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

  // Execution state
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_BACKUP = 2'b10
  } cse_state_t;

  // Accumulator write-back
  typedef struct packed {
    logic a_we;
    logic [NIB_W-1:0] a_data;
    logic b_we;
    logic [NIB_W-1:0] b_data;
  } cse_acc_wr_t;

  // One-cycle event outputs
  typedef struct packed {
    logic pc_step;
    logic conv_start;
    logic cmp_start;
    logic sys_reset;
  } cse_pulse_t;

  // Sticky and steady status
  typedef struct packed {
    logic conversion_done_flag;
    logic watchdog_overflow_flag;
    logic upper_bit_reference_enable_flag;
    logic voltage_drop_detect_en;
    logic watchdog_stopped;
    logic ram_backup;
    logic skip_pending;
  } cse_status_t;

endpackage : cse_pkg

// ---- hdl/cse_event_flag.sv ----
// Purpose: sticky event flag set by hardware, cleared by an instruction
// Assumes: set and clr are one-cycle pulses on clk
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
module cse_event_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Events
  input wire logic set,
  input wire logic clr,
  // Flag
  output logic q
);
  import cse_pkg::*;

  logic flag_ff;
  logic nxt_flag;

  // Set over clear, so a completion landing on the clear is kept
  always_comb begin
    nxt_flag = flag_ff;
    if (clr) begin
      nxt_flag = 1'b0;
    end
    if (set) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign q = flag_ff;

endmodule : cse_event_flag

// ---- hdl/cse_exec.sv ----
// Purpose: executes converter-access and system-control instructions
// Assumes: one instruction per clock cycle with instr_valid high, acc inputs current then
// Notes: results appear one cycle after the instruction is taken
`timescale 1ns/1ns
module cse_exec #(
  parameter bit H_VERSION = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [cse_pkg::INSTR_W-1:0] instr,
  // Accumulators
  input wire logic [cse_pkg::NIB_W-1:0] acc_a,
  input wire logic [cse_pkg::NIB_W-1:0] acc_b,
  output cse_pkg::cse_acc_wr_t acc_wr,
  // Converter core
  input wire logic [cse_pkg::ADC_W-1:0] adc_result,
  input wire logic conv_done,
  output logic [cse_pkg::NIB_W-1:0] converter_control_register,
  output logic [cse_pkg::CMP_W-1:0] cmp_reference,
  // System
  input wire logic converter_irq_enable_bit,
  input wire logic p_flag,
  input wire logic wdt_overflow,
  input wire logic backup_wake,
  output cse_pkg::cse_pulse_t pulses,
  output cse_pkg::cse_status_t status
);
  import cse_pkg::*;

  cse_state_t state_ff;
  cse_state_t nxt_state;
  logic [NIB_W-1:0] conv_ctrl_ff;
  logic [CMP_W-1:0] cmp_ref_ff;
  logic skip_ff;
  logic backup_armed_ff;
  logic wdt_stop_armed_ff;
  logic wdt_stopped_ff;
  logic upper_ref_ff;
  logic vdd_detect_ff;
  cse_acc_wr_t acc_wr_ff;
  cse_acc_wr_t nxt_acc_wr;
  cse_pulse_t pulses_ff;
  logic taken;
  logic exec;
  logic cmp_mode;
  logic adf_q;
  logic wdf_q;
  logic adf_clr;
  logic wdf_clr;
  logic nxt_skip;
  logic op_move_pair;
  logic op_move_low;
  logic op_write_ref;
  logic op_ctrl_to_acc;
  logic op_acc_to_ctrl;
  logic op_start;
  logic op_skip_done;
  logic op_enter_backup;
  logic op_arm_backup;
  logic op_skip_p;
  logic op_arm_wdt;
  logic op_wdt_restart;
  logic op_sw_reset;
  logic op_clr_upper;
  logic op_set_upper;
  logic op_vdd_detect;

  // Instructions are taken only while running
  assign taken = instr_valid && (state_ff == ST_RUN);
  // A word fetched under a pending skip is swallowed as a no-op
  assign exec = taken && !skip_ff;
  assign cmp_mode = conv_ctrl_ff[CONVERTER_MODE_BIT];

  // Decode
  always_comb begin
    op_move_pair = exec && (instr == OP_MOVE_RESULT_TO_ACC_PAIR);
    op_move_low = exec && (instr == OP_MOVE_RESULT_LOW_BITS);
    op_write_ref = exec && (instr == OP_WRITE_COMPARATOR_REFERENCE);
    op_ctrl_to_acc = exec && (instr == OP_COPY_CONVERTER_CONTROL_TO_ACC);
    op_acc_to_ctrl = exec && (instr == OP_COPY_ACC_TO_CONVERTER_CONTROL);
    op_start = exec && (instr == OP_START_CONVERSION);
    op_skip_done = exec && (instr == OP_SKIP_ON_CONVERSION_DONE);
    op_enter_backup = exec && (instr == OP_ENTER_RAM_BACKUP);
    op_arm_backup = exec && (instr == OP_ARM_RAM_BACKUP);
    op_skip_p = exec && (instr == OP_SKIP_ON_BACKUP_RETURN_FLAG);
    op_arm_wdt = exec && (instr == OP_ARM_WATCHDOG_STOP);
    op_wdt_restart = exec && (instr == OP_WATCHDOG_RESTART_SKIP);
    op_sw_reset = exec && (instr == OP_SOFTWARE_SYSTEM_RESET);
    op_clr_upper = exec && (instr == OP_CLEAR_UPPER_REF_ENABLE);
    op_set_upper = exec && (instr == OP_SET_UPPER_REF_ENABLE);
    op_vdd_detect = exec && (instr == OP_ENABLE_VOLTAGE_DROP_DETECT);
  end

  // Conversion-done flag
  assign adf_clr = op_start
    || (op_skip_done && !converter_irq_enable_bit && adf_q);

  cse_event_flag u_adf (
    .clk(clk),
    .resetn(resetn),
    .set(conv_done),
    .clr(adf_clr),
    .q(adf_q)
  );

  // Watchdog overflow flag
  assign wdf_clr = op_wdt_restart && wdf_q;

  cse_event_flag u_wdf (
    .clk(clk),
    .resetn(resetn),
    .set(wdt_overflow),
    .clr(wdf_clr),
    .q(wdf_q)
  );

  // Skip decision; interrupt-enabled skip-on-done never skips
  always_comb begin
    nxt_skip = skip_ff;
    if (taken) begin
      nxt_skip = 1'b0;
      if (op_skip_done && !converter_irq_enable_bit && adf_q) begin
        nxt_skip = 1'b1;
      end
      if (op_skip_p && p_flag) begin
        nxt_skip = 1'b1;
      end
      if (op_wdt_restart && wdf_q) begin
        nxt_skip = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      skip_ff <= 1'b0;
    end else begin
      skip_ff <= nxt_skip;
    end
  end

  // Accumulator write-back
  always_comb begin
    nxt_acc_wr = '0;
    if (op_move_pair && !cmp_mode) begin
      nxt_acc_wr.b_we = 1'b1;
      nxt_acc_wr.b_data = adc_result[9:6];
      nxt_acc_wr.a_we = 1'b1;
      nxt_acc_wr.a_data = adc_result[5:2];
    end
    if (op_move_pair && cmp_mode) begin
      nxt_acc_wr.b_we = 1'b1;
      nxt_acc_wr.b_data = cmp_ref_ff[7:4];
      nxt_acc_wr.a_we = 1'b1;
      nxt_acc_wr.a_data = cmp_ref_ff[3:0];
    end
    if (op_move_low) begin
      nxt_acc_wr.a_we = 1'b1;
      nxt_acc_wr.a_data = {adc_result[1:0], 2'b00};
    end
    if (op_ctrl_to_acc) begin
      nxt_acc_wr.a_we = 1'b1;
      nxt_acc_wr.a_data = conv_ctrl_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_wr_ff <= '0;
    end else begin
      acc_wr_ff <= nxt_acc_wr;
    end
  end

  // Converter control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_ctrl_ff <= CONV_CTRL_RST;
    end else if (op_acc_to_ctrl) begin
      conv_ctrl_ff <= acc_a;
    end
  end

  // Comparator reference; ignored in conversion mode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_ref_ff <= CMP_REF_RST;
    end else if (op_write_ref && cmp_mode) begin
      cmp_ref_ff <= {acc_b, acc_a};
    end
  end

  // Event pulses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pulses_ff <= '0;
    end else begin
      pulses_ff.pc_step <= taken;
      pulses_ff.conv_start <= op_start && !cmp_mode;
      pulses_ff.cmp_start <= op_start && cmp_mode;
      pulses_ff.sys_reset <= op_sw_reset;
    end
  end

  // Arming lasts exactly one following instruction
  always_ff @(posedge clk) begin
    if (!resetn) begin
      backup_armed_ff <= 1'b0;
      wdt_stop_armed_ff <= 1'b0;
    end else if (taken) begin
      backup_armed_ff <= op_arm_backup;
      wdt_stop_armed_ff <= op_arm_wdt;
    end
  end

  // Watchdog stop is one-way until reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wdt_stopped_ff <= 1'b0;
    end else if (op_wdt_restart && wdt_stop_armed_ff) begin
      wdt_stopped_ff <= 1'b1;
    end
  end

  // Upper-bit reference enable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      upper_ref_ff <= 1'b0;
    end else if (op_clr_upper) begin
      upper_ref_ff <= 1'b0;
    end else if (op_set_upper) begin
      upper_ref_ff <= 1'b1;
    end
  end

  // Voltage-drop detect; the variant without it treats the word as no-op
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vdd_detect_ff <= 1'b0;
    end else if (op_vdd_detect && H_VERSION) begin
      vdd_detect_ff <= 1'b1;
    end
  end

  // Run and backup states
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (op_enter_backup && backup_armed_ff) begin
          nxt_state = ST_BACKUP;
        end
      end
      ST_BACKUP: begin
        if (backup_wake) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  assign acc_wr = acc_wr_ff;
  assign pulses = pulses_ff;
  assign converter_control_register = conv_ctrl_ff;
  assign cmp_reference = cmp_ref_ff;
  assign status.conversion_done_flag = adf_q;
  assign status.watchdog_overflow_flag = wdf_q;
  assign status.upper_bit_reference_enable_flag = upper_ref_ff;
  // Detector only armed while actually in backup
  assign status.voltage_drop_detect_en = vdd_detect_ff
    && (state_ff == ST_BACKUP);
  assign status.watchdog_stopped = wdt_stopped_ff;
  assign status.ram_backup = (state_ff == ST_BACKUP);
  assign status.skip_pending = skip_ff;

endmodule : cse_exec

// ---- tb/cse_exec_checker.sv ----
// Purpose: port-level checks on the converter/system executor
// Assumes: one clock, synchronous active-low reset
// Notes: all checks but the counter-step one key on words the executor executes, not swallowed ones
`timescale 1ns/1ns
module cse_exec_checker
  import cse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Instruction side
  input wire logic instr_valid,
  input wire logic [cse_pkg::INSTR_W-1:0] instr,
  input wire logic [cse_pkg::NIB_W-1:0] acc_a,
  input wire logic [cse_pkg::NIB_W-1:0] acc_b,
  input wire cse_pkg::cse_acc_wr_t acc_wr,
  // Converter side
  input wire logic [cse_pkg::ADC_W-1:0] adc_result,
  input wire logic conv_done,
  input wire logic [cse_pkg::NIB_W-1:0] converter_control_register,
  input wire logic [cse_pkg::CMP_W-1:0] cmp_reference,
  // System side
  input wire logic converter_irq_enable_bit,
  input wire logic p_flag,
  input wire logic wdt_overflow,
  input wire logic backup_wake,
  input wire cse_pkg::cse_pulse_t pulses,
  input wire cse_pkg::cse_status_t status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire tk = instr_valid && !status.ram_backup && !status.skip_pending;
  wire md = converter_control_register[CONVERTER_MODE_BIT];

  a_conv_split: assert property (
    tk && !md && instr == OP_MOVE_RESULT_TO_ACC_PAIR |=> acc_wr.b_we &&
    {acc_wr.b_data, acc_wr.a_data} == $past(adc_result[9:2]))
    else $error("conversion split wrong");
  a_cmp_split: assert property (
    tk && md && instr == OP_MOVE_RESULT_TO_ACC_PAIR |=> acc_wr.a_we &&
    {acc_wr.b_data, acc_wr.a_data} == $past(cmp_reference))
    else $error("comparator split wrong");
  a_low_bits_fill: assert property (
    tk && instr == OP_MOVE_RESULT_LOW_BITS |=>
    acc_wr.a_data == {$past(adc_result[1:0]), 2'h0})
    else $error("low bits wrong");
  a_ref_write: assert property (
    tk && instr == OP_WRITE_COMPARATOR_REFERENCE |=> cmp_reference ==
    ($past(md) ? $past({acc_b, acc_a}) : $past(cmp_reference)))
    else $error("reference write wrong");
  a_ctrl_write: assert property (
    tk && instr == OP_COPY_ACC_TO_CONVERTER_CONTROL |=>
    converter_control_register == $past(acc_a))
    else $error("control write wrong");
  a_start_by_mode: assert property (
    tk && instr == OP_START_CONVERSION && !conv_done |=>
    pulses.cmp_start == $past(md) && pulses.conv_start != $past(md)
    && !status.conversion_done_flag)
    else $error("start wrong");
  a_done_skip: assert property (
    tk && instr == OP_SKIP_ON_CONVERSION_DONE && !converter_irq_enable_bit
    && !conv_done |=> !status.conversion_done_flag &&
    status.skip_pending == $past(status.conversion_done_flag))
    else $error("done skip wrong");
  a_backup_entry: assert property (
    tk && instr == OP_ARM_RAM_BACKUP ##1 tk && instr == OP_ENTER_RAM_BACKUP
    |=> status.ram_backup)
    else $error("backup not entered");
  a_wdt_restart: assert property (
    tk && instr == OP_WATCHDOG_RESTART_SKIP && !wdt_overflow |=>
    status.skip_pending == $past(status.watchdog_overflow_flag) &&
    !status.watchdog_overflow_flag)
    else $error("watchdog restart wrong");
  a_irq_done_noop: assert property (
    tk && instr == OP_SKIP_ON_CONVERSION_DONE && converter_irq_enable_bit
    && !conv_done |=> !status.skip_pending &&
    status.conversion_done_flag == $past(status.conversion_done_flag))
    else $error("irq-enabled skip-on-done not a no-op");
  a_word_steps_pc: assert property (
    instr_valid && !status.ram_backup |=> pulses.pc_step)
    else $error("no counter step");
endmodule : cse_exec_checker

bind cse_exec cse_exec_checker u_chk (.clk, .resetn, .instr_valid, .instr,
  .acc_a, .acc_b, .acc_wr, .adc_result, .conv_done,
  .converter_control_register, .cmp_reference, .converter_irq_enable_bit,
  .p_flag, .wdt_overflow, .backup_wake, .pulses, .status);

// ---- tb/cse_exec_bench.sv ----
// Purpose: directed bench for the converter/system executor
// Assumes: words driven 5 ns after the rising edge
// Notes: results read one cycle after each word is taken
`timescale 1ns/1ns
module cse_exec_bench;
  import cse_pkg::*;
  logic clk, resetn, instr_valid, conv_done, converter_irq_enable_bit;
  logic p_flag, wdt_overflow, backup_wake;
  logic [INSTR_W-1:0] instr;
  logic [NIB_W-1:0] acc_a, acc_b, converter_control_register;
  logic [ADC_W-1:0] adc_result;
  logic [CMP_W-1:0] cmp_reference;
  cse_acc_wr_t acc_wr;
  cse_pulse_t pulses;
  cse_status_t status;
  int bad_count = 0;
  int tests_run = 0;

  cse_exec dut (.clk, .resetn, .instr_valid, .instr, .acc_a, .acc_b,
    .acc_wr, .adc_result, .conv_done, .converter_control_register,
    .cmp_reference, .converter_irq_enable_bit, .p_flag, .wdt_overflow,
    .backup_wake, .pulses, .status);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Idle edge first, so valid never falls and rises in one time step
  task automatic ex(input logic [9:0] op, input logic [3:0] a = 4'h0,
      input logic [3:0] b = 4'h0);
    @(posedge clk) #5;
    {instr_valid, instr, acc_a, acc_b} = {1'h1, op, a, b};
    @(posedge clk) #5;
    instr_valid = 1'h0;
  endtask : ex

  // Back-to-back pair, needed where arming covers only the next word
  task automatic ex2(input logic [9:0] o1, input logic [9:0] o2);
    @(posedge clk) #5;
    {instr_valid, instr} = {1'h1, o1};
    @(posedge clk) #5;
    instr = o2;
    @(posedge clk) #5;
    instr_valid = 1'h0;
  endtask : ex2

  task automatic ev(input logic d, input logic w, input logic k);
    {conv_done, wdt_overflow, backup_wake} = {d, w, k};
    @(posedge clk) #5;
    {conv_done, wdt_overflow, backup_wake} = 3'h0;
  endtask : ev

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    {resetn, instr_valid, instr, acc_a, acc_b, adc_result} = '0;
    {conv_done, converter_irq_enable_bit, p_flag, wdt_overflow} = '0;
    backup_wake = 1'h0;
    repeat (8) @(posedge clk);
    #5 resetn = 1'h1;
    ex(OP_COPY_ACC_TO_CONVERTER_CONTROL, 4'h9);
    chk(converter_control_register, 4'h9);
    ex(OP_COPY_CONVERTER_CONTROL_TO_ACC);
    chk({acc_wr.a_we, acc_wr.a_data}, 5'h19);
    ex(OP_WRITE_COMPARATOR_REFERENCE, 4'h5, 4'hA);
    chk(cmp_reference, 8'hA5);
    adc_result = 10'h2D7;
    ex(OP_MOVE_RESULT_TO_ACC_PAIR);
    chk({acc_wr.b_data, acc_wr.a_data}, 8'hA5);
    ex(OP_START_CONVERSION);
    chk({pulses.conv_start, pulses.cmp_start}, 2'h1);
    $display("Test comparator mode done");
    ex(OP_COPY_ACC_TO_CONVERTER_CONTROL, 4'h1);
    ex(OP_WRITE_COMPARATOR_REFERENCE, 4'h3, 4'hC);
    chk(cmp_reference, 8'hA5);
    ex(OP_MOVE_RESULT_TO_ACC_PAIR);
    chk({acc_wr.b_data, acc_wr.a_data}, adc_result[9:2]);
    ex(OP_MOVE_RESULT_LOW_BITS, 4'hF);
    chk(acc_wr.a_data, {adc_result[1:0], 2'h0});
    ev(1'h1, 1'h0, 1'h0);
    ex(OP_START_CONVERSION);
    chk({pulses.conv_start, status.conversion_done_flag}, 2'h2);
    ev(1'h1, 1'h0, 1'h0);
    converter_irq_enable_bit = 1'h1;
    ex(OP_SKIP_ON_CONVERSION_DONE);
    chk({status.skip_pending, status.conversion_done_flag}, 2'h1);
    converter_irq_enable_bit = 1'h0;
    ex(OP_SKIP_ON_CONVERSION_DONE);
    chk({status.skip_pending, status.conversion_done_flag}, 2'h2);
    ex(OP_SET_UPPER_REF_ENABLE);
    chk({pulses.pc_step, status.upper_bit_reference_enable_flag},
      2'h2);
    ex(OP_SKIP_ON_CONVERSION_DONE);
    chk(status.skip_pending, 1'h0);
    $display("Test conversion mode done");
    for (int i = 0; i < 2; i++) begin
      p_flag = i[0];
      ex(OP_SKIP_ON_BACKUP_RETURN_FLAG);
      chk(status.skip_pending, i[0]);
      ex(OP_NO_OPERATION);
    end
    ev(1'h0, 1'h1, 1'h0);
    ex(OP_WATCHDOG_RESTART_SKIP);
    chk({status.skip_pending, status.watchdog_overflow_flag},
      2'h2);
    ex(OP_NO_OPERATION);
    chk(status.watchdog_stopped, 1'h0);
    ex2(OP_ARM_WATCHDOG_STOP, OP_WATCHDOG_RESTART_SKIP);
    chk(status.watchdog_stopped, 1'h1);
    ex(OP_SET_UPPER_REF_ENABLE);
    chk(status.upper_bit_reference_enable_flag, 1'h1);
    ex(OP_CLEAR_UPPER_REF_ENABLE);
    chk(status.upper_bit_reference_enable_flag, 1'h0);
    ex(OP_SOFTWARE_SYSTEM_RESET);
    chk(pulses.sys_reset, 1'h1);
    ex(OP_NO_OPERATION);
    chk({pulses.pc_step, converter_control_register}, 5'h11);
    $display("Test system words done");
    ex(OP_ENABLE_VOLTAGE_DROP_DETECT);
    ex2(OP_ARM_RAM_BACKUP, OP_NO_OPERATION);
    ex(OP_ENTER_RAM_BACKUP);
    chk(status.ram_backup, 1'h0);
    ex2(OP_ARM_RAM_BACKUP, OP_ENTER_RAM_BACKUP);
    chk({status.ram_backup, status.voltage_drop_detect_en},
      2'h3);
    ex(OP_SET_UPPER_REF_ENABLE);
    chk({pulses.pc_step, status.upper_bit_reference_enable_flag},
      2'h0);
    ev(1'h0, 1'h0, 1'h1);
    chk(status.ram_backup, 1'h0);
    $display("Test backup done");
    wrap_up();
  end

  // Whole run is well under 10 us; this only catches a hang
  initial begin
    #100000;
    bad_count++;
    $display("Error at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule : cse_exec_bench
